// file: tcd_regs.svh
// Constants for the tile configuration register bank: register numbers,
// field positions, reset values and decoder widths.
// Assumes it is included by bare name from every file that needs it.
`ifndef TCD_REGS_SVH
`define TCD_REGS_SVH

// Register numbers on the configuration port.
`define TCD_ADDR_W 8
`define TCD_OFS_IDENTITY 8'h00
`define TCD_OFS_PERMS 8'h04
`define TCD_OFS_DBG_CAUSE 8'h05
`define TCD_OFS_CLK_DIV 8'h06
`define TCD_OFS_SECURITY 8'h07
`define TCD_OFS_CORE7_STATUS 8'h67

// Field positions.
`define TCD_PERM_RO_ALL_BIT 31
`define TCD_PERM_RO_SS_BIT 0
`define TCD_DBG_REQ_BIT 0
`define TCD_DBG_MODE_BIT 1
`define TCD_CLK_OFF_BIT 31
`define TCD_DIV_MSB 15
`define TCD_DIV_W 16

// Reset values.
`define TCD_PERMS_RST 32'h0000_0000
`define TCD_DBG_CAUSE_RST 32'h0000_0000
`define TCD_CLK_DIV_RST 32'h0000_0000

// Arbitrary identity word of this tile; the value has no meaning.
`define TCD_TILE_ID_DEFAULT 32'h5a5a_0001

`endif

// file: tcd_pkg.sv
// Types shared by the tile configuration register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package tcd_pkg;

  // Origin of a configuration request.
  typedef enum logic [1:0] {
    TCD_SRC_LOCAL = 2'h0,
    TCD_SRC_SYSTEM_SWITCH = 2'h1,
    TCD_SRC_DEBUG_SCRATCH = 2'h3,
    TCD_SRC_JTAG = 2'h2
  } tcd_src_t;

endpackage

// file: tcd_access_guard.sv
// Write-permission check for config read-write registers.
// Assumes the permission bits and the source come from the same clock domain.
`timescale 1ns/1ps

module tcd_access_guard (
  // Permission bits.
  input wire logic perm_ro_all,
  input wire logic perm_ro_ss,
  // Request origin.
  input wire tcd_pkg::tcd_src_t src,
  // Verdict.
  output logic write_allowed
);

  // Decides whether the given source is held to read-only access.
  function automatic logic is_restricted(input logic ro_all, input logic ro_ss,
                                         input tcd_pkg::tcd_src_t s);
    logic r;
    r = 1'b0;
    if (ro_all && (s != tcd_pkg::TCD_SRC_LOCAL)) begin
      r = 1'b1;
    end
    if (ro_ss && (s == tcd_pkg::TCD_SRC_SYSTEM_SWITCH)) begin
      r = 1'b1;
    end
    return r;
  endfunction

  // Local processor writes are never restricted.
  always_comb begin
    write_allowed = !is_restricted(perm_ro_all, perm_ro_ss, src);
  end

endmodule

// file: tcd_clk_div.sv
// Tile clock divider: produces a one-cycle enable that paces the tile clock.
// Assumes ref_clk stands in for the PLL clock and all inputs share its domain.
`timescale 1ns/1ps
`include "tcd_regs.svh"

module tcd_clk_div (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Controls.
  input wire logic [`TCD_DIV_W-1:0] div_value,
  input wire logic div_enable,
  input wire logic clk_off,
  // Paced enable.
  output logic tile_clk_en
);

  logic [`TCD_DIV_W-1:0] cnt_reg;
  logic [`TCD_DIV_W-1:0] cnt_next;
  logic en_reg;
  logic en_next;

  // Unless clk_off holds the enable low, a divider value of zero or one, or a divider that is not enabled, passes every edge; otherwise one in N.
  always_comb begin
    cnt_next = cnt_reg;
    en_next = 1'b0;
    if (clk_off) begin
      cnt_next = '0;
      en_next = 1'b0;
    end else if (!div_enable || (div_value <= `TCD_DIV_W'(1))) begin
      cnt_next = '0;
      en_next = 1'b1;
    end else if (cnt_reg >= div_value - `TCD_DIV_W'(1)) begin
      cnt_next = '0;
      en_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + `TCD_DIV_W'(1);
    end
  end

  // Registers the counter and the enable.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
      en_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      en_reg <= en_next;
    end
  end

  assign tile_clk_en = en_reg;

endmodule

// file: tcd_cfg_regs.sv
// Tile configuration register bank: identity, debug permissions, debug
// interrupt cause, tile clock divider, security copy and core 7 status view.
// Assumes every input is driven by logic on ref_clk; requests are taken one
// per cycle and answered one cycle later.
`timescale 1ns/1ps
`include "tcd_regs.svh"

// Notes on behaviour
// - Top permission bit: remote sources read-only.
// - Low permission bit: system switch read-only.
// - Debug-cause bit 0 raises debug interrupt.
// - Debug-cause bit 1 shows debug mode.
// - Tile clock divides by sixteen-bit value.
// - Clock-divider top bit gates tile clock off.
// - Divider acts only when separately enabled.
// - Security register returns OTP copy, read-only.
// - Offset 0x67 shows core 7 status.
// - Offset zero returns tile identity, read-only.
module tcd_cfg_regs #(
  parameter logic [31:0] TILE_ID = `TCD_TILE_ID_DEFAULT
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Configuration request.
  input wire logic cfg_req,
  input wire logic cfg_wr,
  input wire logic [`TCD_ADDR_W-1:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire tcd_pkg::tcd_src_t cfg_src,
  // Configuration answer.
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  output logic cfg_err,
  // Processor state seen by the bank.
  input wire logic debug_mode,
  input wire logic [31:0] core7_status,
  input wire logic [31:0] otp_security_word,
  input wire logic div_enable,
  // Controls driven to the tile.
  output logic debug_irq,
  output logic tile_clk_en,
  output logic perm_ro_all,
  output logic perm_ro_ss
);

  // Control registers.
  logic perm_ro_all_reg;
  logic perm_ro_all_next;
  logic perm_ro_ss_reg;
  logic perm_ro_ss_next;
  logic dbg_req_reg;
  logic dbg_req_next;
  logic clk_off_reg;
  logic clk_off_next;
  logic [`TCD_DIV_W-1:0] div_value_reg;
  logic [`TCD_DIV_W-1:0] div_value_next;

  // Answer registers.
  logic ack_reg;
  logic ack_next;
  logic err_reg;
  logic err_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // Helper nets.
  logic write_allowed;
  logic wr_ok;

  // Tells whether a register number is mapped.
  function automatic logic is_mapped(input logic [`TCD_ADDR_W-1:0] a);
    return (a == `TCD_OFS_IDENTITY) || (a == `TCD_OFS_PERMS) ||
           (a == `TCD_OFS_DBG_CAUSE) || (a == `TCD_OFS_CLK_DIV) ||
           (a == `TCD_OFS_SECURITY) || (a == `TCD_OFS_CORE7_STATUS);
  endfunction

  // Tells whether a register number names a config read-write register.
  function automatic logic is_writable(input logic [`TCD_ADDR_W-1:0] a);
    return (a == `TCD_OFS_PERMS) || (a == `TCD_OFS_DBG_CAUSE) ||
           (a == `TCD_OFS_CLK_DIV);
  endfunction

  // Source permission check.
  tcd_access_guard tcd_access_guard_inst (
    .perm_ro_all(perm_ro_all_reg),
    .perm_ro_ss(perm_ro_ss_reg),
    .src(cfg_src),
    .write_allowed(write_allowed)
  );

  // Tile clock pacing.
  tcd_clk_div tcd_clk_div_inst (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .div_value(div_value_reg),
    .div_enable(div_enable),
    .clk_off(clk_off_reg),
    .tile_clk_en(tile_clk_en)
  );

  // A write lands only on a writable register from a permitted source.
  assign wr_ok = cfg_req && cfg_wr && is_writable(cfg_addr) && write_allowed;

  // Next values of the control registers.
  always_comb begin
    perm_ro_all_next = perm_ro_all_reg;
    perm_ro_ss_next = perm_ro_ss_reg;
    dbg_req_next = dbg_req_reg;
    clk_off_next = clk_off_reg;
    div_value_next = div_value_reg;
    if (wr_ok) begin
      unique case (cfg_addr)
        `TCD_OFS_PERMS: begin
          perm_ro_all_next = cfg_wdata[`TCD_PERM_RO_ALL_BIT];
          perm_ro_ss_next = cfg_wdata[`TCD_PERM_RO_SS_BIT];
        end
        `TCD_OFS_DBG_CAUSE: begin
          dbg_req_next = cfg_wdata[`TCD_DBG_REQ_BIT];
        end
        `TCD_OFS_CLK_DIV: begin
          clk_off_next = cfg_wdata[`TCD_CLK_OFF_BIT];
          div_value_next = cfg_wdata[`TCD_DIV_MSB:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Registers the control state.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      perm_ro_all_reg <= 1'(`TCD_PERMS_RST >> `TCD_PERM_RO_ALL_BIT);
      perm_ro_ss_reg <= 1'(`TCD_PERMS_RST >> `TCD_PERM_RO_SS_BIT);
      dbg_req_reg <= 1'(`TCD_DBG_CAUSE_RST >> `TCD_DBG_REQ_BIT);
      clk_off_reg <= 1'(`TCD_CLK_DIV_RST >> `TCD_CLK_OFF_BIT);
      div_value_reg <= `TCD_DIV_W'(`TCD_CLK_DIV_RST);
    end else begin
      perm_ro_all_reg <= perm_ro_all_next;
      perm_ro_ss_reg <= perm_ro_ss_next;
      dbg_req_reg <= dbg_req_next;
      clk_off_reg <= clk_off_next;
      div_value_reg <= div_value_next;
    end
  end

  // Read data, answer and error for the request taken this cycle.
  always_comb begin
    ack_next = cfg_req;
    err_next = 1'b0;
    rdata_next = 32'h0000_0000;
    if (cfg_req) begin
      if (!is_mapped(cfg_addr)) begin
        err_next = 1'b1;
      end else if (cfg_wr && is_writable(cfg_addr) && !write_allowed) begin
        err_next = 1'b1;
      end
      if (!cfg_wr) begin
        unique case (cfg_addr)
          `TCD_OFS_IDENTITY: rdata_next = TILE_ID;
          `TCD_OFS_PERMS: begin
            rdata_next[`TCD_PERM_RO_ALL_BIT] = perm_ro_all_reg;
            rdata_next[`TCD_PERM_RO_SS_BIT] = perm_ro_ss_reg;
          end
          `TCD_OFS_DBG_CAUSE: begin
            rdata_next[`TCD_DBG_REQ_BIT] = dbg_req_reg;
            rdata_next[`TCD_DBG_MODE_BIT] = debug_mode;
          end
          `TCD_OFS_CLK_DIV: begin
            rdata_next[`TCD_CLK_OFF_BIT] = clk_off_reg;
            rdata_next[`TCD_DIV_MSB:0] = div_value_reg;
          end
          `TCD_OFS_SECURITY: rdata_next = otp_security_word;
          `TCD_OFS_CORE7_STATUS: rdata_next = core7_status;
          default: rdata_next = 32'h0000_0000;
        endcase
      end
    end
  end

  // Registers the answer.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= ack_next;
      err_reg <= err_next;
      rdata_reg <= rdata_next;
    end
  end

  // Outputs straight from flip-flops.
  assign cfg_ack = ack_reg;
  assign cfg_err = err_reg;
  assign cfg_rdata = rdata_reg;
  assign debug_irq = dbg_req_reg;
  assign perm_ro_all = perm_ro_all_reg;
  assign perm_ro_ss = perm_ro_ss_reg;

endmodule

// file: tcd_cfg_regs_chk.sv
// Checker for the tile configuration register bank.
// Assumes it is bound to tcd_cfg_regs and sees only that module's ports.
`timescale 1ns/1ps
`include "tcd_regs.svh"

module tcd_cfg_regs_chk #(
  parameter logic [31:0] TILE_ID = `TCD_TILE_ID_DEFAULT
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Configuration request and answer.
  input wire logic cfg_req,
  input wire logic cfg_wr,
  input wire logic [`TCD_ADDR_W-1:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire tcd_pkg::tcd_src_t cfg_src,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_err,
  // Tile side.
  input wire logic debug_mode,
  input wire logic [31:0] core7_status,
  input wire logic [31:0] otp_security_word,
  input wire logic div_enable,
  input wire logic debug_irq,
  input wire logic tile_clk_en,
  input wire logic perm_ro_all,
  input wire logic perm_ro_ss
);
  // Request decodes; ctl marks the writable control registers.
  wire rd = cfg_req && !cfg_wr;
  wire wr = cfg_req && cfg_wr;
  wire ctl = cfg_addr inside {8'h04, 8'h05, 8'h06};
  wire loc = cfg_src == tcd_pkg::TCD_SRC_LOCAL;
  wire [2:0] st = {debug_irq, perm_ro_all, perm_ro_ss};

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // Answer timing, identity and read-only views.
  AST_ACK: assert property (cfg_req |=> cfg_ack) else $error("no answer");
  AST_IDLE: assert property (
    !cfg_req |=> !cfg_ack && !cfg_err && cfg_rdata == 32'h0)
    else $error("idle answer");
  AST_ID: assert property (
    rd && cfg_addr == 8'h00 |=> cfg_rdata == TILE_ID && !cfg_err)
    else $error("identity wrong");
  AST_SEC: assert property (
    rd && cfg_addr == 8'h07 |=> cfg_rdata == $past(otp_security_word))
    else $error("security wrong");
  AST_CORE7: assert property (
    rd && cfg_addr == 8'h67 |=> cfg_rdata == $past(core7_status))
    else $error("core7 wrong");
  AST_MODE: assert property (
    rd && cfg_addr == 8'h05 |=> cfg_rdata == {30'h0, $past(debug_mode), $past(debug_irq)})
    else $error("cause wrong");
  // Permission restrictions refuse writes and leave state alone; a local debug-cause write loads bit 0 into the irq.
  AST_RO_ALL: assert property (
    wr && ctl && perm_ro_all && !loc |=> cfg_err && $stable(st))
    else $error("remote write taken");
  AST_RO_SS: assert property (
    wr && ctl && perm_ro_ss && cfg_src == tcd_pkg::TCD_SRC_SYSTEM_SWITCH
    |=> cfg_err && $stable(st)) else $error("switch write taken");
  AST_IRQ: assert property (
    wr && loc && cfg_addr == 8'h05 |=> debug_irq == $past(cfg_wdata[0]))
    else $error("irq not set");
endmodule

bind tcd_cfg_regs tcd_cfg_regs_chk #(.TILE_ID(TILE_ID)) tcd_cfg_regs_chk_inst (.ref_clk,
  .sys_rst, .cfg_req, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_src, .cfg_ack, .cfg_rdata,
  .cfg_err, .debug_mode, .core7_status, .otp_security_word, .div_enable, .debug_irq,
  .tile_clk_en, .perm_ro_all, .perm_ro_ss);

// file: tcd_cfg_regs_tb.sv
// Self-checking bench for the tile configuration register bank.
// Assumes the checker is bound in; the bench drives every port itself.
`timescale 1ns/1ps
`include "tcd_regs.svh"

module tcd_cfg_regs_tb;
  // Arbitrary identity word for this bench.
  localparam logic [31:0] ID = 32'h0123_4567;
  localparam logic [31:0] C7 = 32'h1234_abcd;
  localparam logic [31:0] OTP = 32'h0f0f_3c3c;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cfg_req = 1'b0;
  logic cfg_wr = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [31:0] cfg_wdata = 32'h0;
  tcd_pkg::tcd_src_t cfg_src = tcd_pkg::TCD_SRC_LOCAL;
  logic debug_mode = 1'b0;
  logic div_enable = 1'b0;
  logic cfg_ack, cfg_err, debug_irq, tile_clk_en, perm_ro_all, perm_ro_ss;
  logic [31:0] cfg_rdata;
  int miscompares = 0;
  int comparisons = 0;

  // Clock at 25 MHz.
  always #20 ref_clk = ~ref_clk;

  tcd_cfg_regs #(.TILE_ID(ID)) tcd_cfg_regs_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_src(cfg_src), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .cfg_err(cfg_err),
    .debug_mode(debug_mode), .core7_status(C7), .otp_security_word(OTP),
    .div_enable(div_enable), .debug_irq(debug_irq), .tile_clk_en(tile_clk_en),
    .perm_ro_all(perm_ro_all), .perm_ro_ss(perm_ro_ss));

  // Compares one value and counts the outcome.
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task wrap_up;
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // One request held for one edge, then its one-cycle answer is compared.
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d,
           input tcd_pkg::tcd_src_t s, input logic [31:0] er, input logic ee);
    @(posedge ref_clk);
    cfg_req <= 1'b1;
    cfg_wr <= w;
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_src <= s;
    @(posedge ref_clk);
    cfg_req <= 1'b0;
    #1;
    check("ack", {31'h0, cfg_ack}, 32'h1);
    check("rdata", cfg_rdata, er);
    check("err", {31'h0, cfg_err}, {31'h0, ee});
  endtask

  // Counts tile clock ticks over 40 cycles after a short settle.
  task ticks(input int n);
    int c;
    c = 0;
    repeat (3) @(posedge ref_clk);
    repeat (40) begin
      @(posedge ref_clk);
      #1;
      if (tile_clk_en === 1'b1) c++;
    end
    check("ticks", c, n);
  endtask

  // Main sequence of register accesses.
  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
    check("rst", {29'h0, debug_irq, perm_ro_all, perm_ro_ss}, 32'h0);
    acc(1'b1, 8'h00, 32'hffff_ffff, tcd_pkg::TCD_SRC_LOCAL, 32'h0, 1'b0);
    acc(1'b0, 8'h00, 32'h0, tcd_pkg::TCD_SRC_LOCAL, ID, 1'b0);
    acc(1'b1, 8'h07, 32'h0, tcd_pkg::TCD_SRC_LOCAL, 32'h0, 1'b0);
    acc(1'b0, 8'h07, 32'h0, tcd_pkg::TCD_SRC_LOCAL, OTP, 1'b0);
    acc(1'b0, 8'h67, 32'h0, tcd_pkg::TCD_SRC_JTAG, C7, 1'b0);
    acc(1'b0, 8'h01, 32'h0, tcd_pkg::TCD_SRC_LOCAL, 32'h0, 1'b1);
    acc(1'b1, 8'h05, 32'hffff_ffff, tcd_pkg::TCD_SRC_LOCAL, 32'h0, 1'b0);
    check("irq", {31'h0, debug_irq}, 32'h1);
    @(posedge ref_clk);
    debug_mode <= 1'b1;
    acc(1'b0, 8'h05, 32'h0, tcd_pkg::TCD_SRC_LOCAL, 32'h3, 1'b0);
    @(posedge ref_clk);
    debug_mode <= 1'b0;
    acc(1'b0, 8'h05, 32'h0, tcd_pkg::TCD_SRC_LOCAL, 32'h1, 1'b0);
    acc(1'b1, 8'h04, 32'hffff_ffff, tcd_pkg::TCD_SRC_LOCAL, 32'h0, 1'b0);
    acc(1'b0, 8'h04, 32'h0, tcd_pkg::TCD_SRC_LOCAL, 32'h8000_0001, 1'b0);
    for (int i = 1; i < 4; i++) begin
      acc(1'b1, 8'h05, 32'h0, tcd_pkg::tcd_src_t'(i), 32'h0, 1'b1);
      check("irq kept", {31'h0, debug_irq}, 32'h1);
    end
    acc(1'b1, 8'h04, 32'h1, tcd_pkg::TCD_SRC_LOCAL, 32'h0, 1'b0);
    acc(1'b1, 8'h05, 32'h0, tcd_pkg::TCD_SRC_JTAG, 32'h0, 1'b0);
    acc(1'b1, 8'h05, 32'h1, tcd_pkg::TCD_SRC_SYSTEM_SWITCH, 32'h0, 1'b1);
    check("irq off", {31'h0, debug_irq}, 32'h0);
    @(posedge ref_clk);
    div_enable <= 1'b1;
    acc(1'b1, 8'h06, 32'hffff_ffff, tcd_pkg::TCD_SRC_LOCAL, 32'h0, 1'b0);
    acc(1'b0, 8'h06, 32'h0, tcd_pkg::TCD_SRC_LOCAL, 32'h8000_ffff, 1'b0);
    ticks(0);
    acc(1'b1, 8'h06, 32'h4, tcd_pkg::TCD_SRC_LOCAL, 32'h0, 1'b0);
    ticks(10);
    @(posedge ref_clk);
    div_enable <= 1'b0;
    ticks(40);
    // Mid-run reset with the irq and switch restriction set must clear them.
    acc(1'b1, 8'h05, 32'h1, tcd_pkg::TCD_SRC_LOCAL, 32'h0, 1'b0);
    @(posedge ref_clk);
    div_enable <= 1'b1;
    sys_rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
    check("rst again", {29'h0, debug_irq, perm_ro_all, perm_ro_ss}, 32'h0);
    acc(1'b0, 8'h06, 32'h0, tcd_pkg::TCD_SRC_LOCAL, 32'h0, 1'b0);
    acc(1'b0, 8'h04, 32'h0, tcd_pkg::TCD_SRC_LOCAL, 32'h0, 1'b0);
    ticks(40);
    wrap_up;
  end

  // Watchdog against a hang.
  initial begin
    #100000;
    miscompares++;
    wrap_up;
  end
endmodule
